// File: design/split_result_pkg.sv
/*
  Package for the split result register bank: register offsets, field
  positions, reset values and the carrier structs.
  Assumes one core clock and an 8-bit register address space.
*/
package split_result_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS_ONE      = 8'h00;
  localparam logic [7:0] OFS_STATUS_TWO      = 8'h01;
  localparam logic [7:0] OFS_RESERVED_A      = 8'h02;
  localparam logic [7:0] OFS_LOW_GROUP0      = 8'h03;
  localparam logic [7:0] OFS_LOW_GROUP1      = 8'h04;
  localparam logic [7:0] OFS_LOW_GROUP2      = 8'h05;
  localparam logic [7:0] OFS_HIGH_SUPPLY     = 8'h06;
  localparam logic [7:0] OFS_HIGH_ONCHIP     = 8'h07;
  localparam logic [7:0] OFS_HIGH_REMOTE     = 8'h08;
  localparam logic [7:0] OFS_HIGH_INPUT2     = 8'h09;
  localparam logic [7:0] OFS_SETUP_ONE       = 8'h18;
  localparam logic [7:0] OFS_SETUP_TWO       = 8'h19;
  localparam logic [7:0] OFS_SETUP_THREE     = 8'h1a;
  localparam logic [7:0] OFS_MASK_ONE        = 8'h1d;
  localparam logic [7:0] OFS_MASK_TWO        = 8'h1e;
  localparam logic [7:0] OFS_ONCHIP_TRIM     = 8'h1f;
  localparam logic [7:0] OFS_REMOTE_TRIM     = 8'h20;
  localparam logic [7:0] OFS_REMOTE_UPPER    = 8'h27;
  localparam logic [7:0] OFS_REMOTE_LOWER    = 8'h28;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO            = 8'h00;
  localparam logic [7:0] RST_REMOTE_UPPER    = 8'hff;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int         STAT1_REMOTE_HIGH   = 2;
  localparam int         STAT1_REMOTE_LOW    = 3;
  localparam int         SETUP1_ALERT_POL    = 3;
  localparam logic [1:0] CH_SUPPLY           = 2'h0;
  localparam logic [1:0] CH_ONCHIP           = 2'h1;
  localparam logic [1:0] CH_REMOTE           = 2'h2;
  localparam logic [1:0] CH_INPUT2           = 2'h3;
  localparam int         LOW_POS_EVEN_CH     = 2;
  localparam int         LOW_POS_ODD_CH      = 0;
  localparam int         NUM_CH              = 4;
  localparam int         NUM_GROUPS          = 2;

  // ---------------------------------------------------------------------
  // Carrier structs
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic [9:0] value;
  } conv_s;

endpackage

// File: design/group_lock.sv
/*
  Freeze tracker for the high-bits registers, one flag per low-bits group.
  Assumes read strobes are one-cycle pulses on core_clk.
*/
`timescale 1ns/1ps
module group_lock
  import split_result_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  ce,
  input  wire logic [NUM_GROUPS-1:0] low_read,
  input  wire logic [NUM_GROUPS-1:0] high_read,
  output logic      [NUM_GROUPS-1:0] locked
);

  logic [NUM_GROUPS-1:0] lock_q;

  // A high read of a frozen group releases it; a low read freezes it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_q <= '0;
    end else if (ce) begin
      lock_q <= (lock_q & ~high_read) | low_read;
    end
  end

  assign locked = lock_q;

endmodule // group_lock

// File: design/limit_check.sv
/*
  Window comparison of one 10-bit result against 8-bit limits.
  Assumes limits weigh the same as the upper eight result bits.
*/
`timescale 1ns/1ps
module limit_check (
  input  wire logic [9:0] result,
  input  wire logic [7:0] upper,
  input  wire logic [7:0] lower,
  output logic            above,
  output logic            at_or_below
);

  // Upper limit uses greater-than, lower limit less-than-or-equal.
  assign above       = (result[9:2] > upper);
  assign at_or_below = (result[9:2] <= lower);

endmodule // limit_check

// File: design/split_result_bank.sv
/*
  Register bank of the monitor: results split into high and low parts,
  freeze on low-bits reads, status flags, masks, limits and alert output.
  Assumes a register port on core_clk carrying one-cycle read and write
  strobes and a conversion port delivering one result per valid pulse.
*/
`timescale 1ns/1ps
module split_result_bank
  import split_result_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire reg_req_s   reg_req,
  output logic      [7:0] reg_rdata,
  input  wire conv_s      conv,
  output logic            alert_out
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic int low_pos(input logic [1:0] ch);
    return ch[0] ? LOW_POS_ODD_CH : LOW_POS_EVEN_CH;
  endfunction

  function automatic logic is_high_addr(input logic [7:0] a);
    return (a >= OFS_HIGH_SUPPLY) && (a <= OFS_HIGH_INPUT2);
  endfunction

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic [9:0]            live_q   [NUM_CH];
  logic [7:0]            high_q   [NUM_CH];
  logic [7:0]            low_q    [NUM_GROUPS];
  logic [7:0]            status_one_q;
  logic [7:0]            status_two_q;
  logic [7:0]            setup_one_q;
  logic [7:0]            setup_two_q;
  logic [7:0]            setup_three_q;
  logic [7:0]            mask_one_q;
  logic [7:0]            mask_two_q;
  logic [7:0]            onchip_trim_q;
  logic [7:0]            remote_trim_q;
  logic [7:0]            remote_upper_q;
  logic [7:0]            remote_lower_q;
  logic [7:0]            rdata_q;
  logic                  alert_q;
  logic [NUM_GROUPS-1:0] low_read;
  logic [NUM_GROUPS-1:0] high_read;
  logic [NUM_GROUPS-1:0] locked;
  logic [1:0]            rd_ch;
  logic                  remote_above;
  logic                  remote_below;
  logic                  set_high;
  logic                  set_low;
  logic                  rd_status_one;
  logic                  rd_status_two;
  logic [9:0]            conv_value;

  assign conv_value = conv.value;
  assign rd_ch      = reg_req.addr[1:0] - OFS_HIGH_SUPPLY[1:0];

  // ---------------------------------------------------------------------
  // Read decode for the freeze tracker
  // ---------------------------------------------------------------------
  always_comb begin
    low_read  = '0;
    high_read = '0;
    if (reg_req.rd) begin
      if (reg_req.addr == OFS_LOW_GROUP0) begin
        low_read[0] = 1'h1;
      end
      if (reg_req.addr == OFS_LOW_GROUP1) begin
        low_read[1] = 1'h1;
      end
      // A high read only releases; it never freezes anything.
      if (is_high_addr(reg_req.addr)) begin
        high_read[rd_ch[1]] = 1'h1;
      end
    end
  end

  group_lock u_group_lock (
    .core_clk  (core_clk),
    .srst      (srst),
    .ce        (ce),
    .low_read  (low_read),
    .high_read (high_read),
    .locked    (locked)
  );

  // ---------------------------------------------------------------------
  // Result storage
  // ---------------------------------------------------------------------
  // Live copies keep the newest result even while the high byte is frozen.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        live_q[i] <= '0;
      end
    end else if (ce && conv.valid) begin
      live_q[conv.chan] <= conv.value;
    end
  end

  // High bytes follow the live copy unless their group is frozen.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        high_q[i] <= RST_ZERO;
      end
    end else if (ce) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!locked[i/2]) begin
          high_q[i] <= live_q[i][9:2];
        end
      end
    end
  end

  // Low bits are never frozen.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        low_q[g] <= RST_ZERO;
      end
    end else if (ce && conv.valid) begin
      low_q[conv.chan[1]][low_pos(conv.chan) +: 2]
        <= conv.value[1:0];
    end
  end

  // ---------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      setup_one_q    <= RST_ZERO;
      setup_two_q    <= RST_ZERO;
      setup_three_q  <= RST_ZERO;
      mask_one_q     <= RST_ZERO;
      mask_two_q     <= RST_ZERO;
      onchip_trim_q  <= RST_ZERO;
      remote_trim_q  <= RST_ZERO;
      remote_upper_q <= RST_REMOTE_UPPER;
      remote_lower_q <= RST_ZERO;
    end else if (ce && reg_req.wr) begin
      case (reg_req.addr)
        OFS_SETUP_ONE:    setup_one_q    <= reg_req.wdata;
        OFS_SETUP_TWO:    setup_two_q    <= reg_req.wdata;
        OFS_SETUP_THREE:  setup_three_q  <= reg_req.wdata;
        OFS_MASK_ONE:     mask_one_q     <= reg_req.wdata;
        OFS_MASK_TWO:     mask_two_q     <= reg_req.wdata;
        OFS_ONCHIP_TRIM:  onchip_trim_q  <= reg_req.wdata;
        OFS_REMOTE_TRIM:  remote_trim_q  <= reg_req.wdata;
        OFS_REMOTE_UPPER: remote_upper_q <= reg_req.wdata;
        OFS_REMOTE_LOWER: remote_lower_q <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Limit comparison and status flags
  // ---------------------------------------------------------------------
  limit_check u_remote_limit (
    .result      (conv.value),
    .upper       (remote_upper_q),
    .lower       (remote_lower_q),
    .above       (remote_above),
    .at_or_below (remote_below)
  );

  assign set_high = conv.valid && (conv.chan == CH_REMOTE) && remote_above
                    && !mask_one_q[STAT1_REMOTE_HIGH];
  assign set_low  = conv.valid && (conv.chan == CH_REMOTE) && remote_below
                    && !mask_one_q[STAT1_REMOTE_LOW];
  assign rd_status_one = reg_req.rd && (reg_req.addr == OFS_STATUS_ONE);
  assign rd_status_two = reg_req.rd && (reg_req.addr == OFS_STATUS_TWO);

  // Flags clear on read; a violation in the same cycle wins.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_one_q <= RST_ZERO;
    end else if (ce) begin
      if (rd_status_one) begin
        status_one_q <= RST_ZERO;
      end
      if (set_high) begin
        status_one_q[STAT1_REMOTE_HIGH] <= 1'h1;
      end
      if (set_low) begin
        status_one_q[STAT1_REMOTE_LOW] <= 1'h1;
      end
    end
  end

  // No channel of this bank reports into the second status register.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_two_q <= RST_ZERO;
    end else if (ce && rd_status_two) begin
      status_two_q <= RST_ZERO;
    end
  end

  // ---------------------------------------------------------------------
  // Alert output
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      alert_q <= 1'h0;
    end else if (ce) begin
      alert_q <= ((|status_one_q) || (|status_two_q))
                 ? setup_one_q[SETUP1_ALERT_POL]
                 : !setup_one_q[SETUP1_ALERT_POL];
    end
  end

  assign alert_out = alert_q;

  // ---------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= RST_ZERO;
    end else if (ce && reg_req.rd) begin
      case (reg_req.addr)
        OFS_STATUS_ONE:   rdata_q <= status_one_q;
        OFS_STATUS_TWO:   rdata_q <= status_two_q;
        OFS_LOW_GROUP0:   rdata_q <= low_q[0];
        OFS_LOW_GROUP1:   rdata_q <= low_q[1];
        OFS_HIGH_SUPPLY:  rdata_q <= high_q[CH_SUPPLY];
        OFS_HIGH_ONCHIP:  rdata_q <= high_q[CH_ONCHIP];
        OFS_HIGH_REMOTE:  rdata_q <= high_q[CH_REMOTE];
        OFS_HIGH_INPUT2:  rdata_q <= high_q[CH_INPUT2];
        OFS_SETUP_ONE:    rdata_q <= setup_one_q;
        OFS_SETUP_TWO:    rdata_q <= setup_two_q;
        OFS_SETUP_THREE:  rdata_q <= setup_three_q;
        OFS_MASK_ONE:     rdata_q <= mask_one_q;
        OFS_MASK_TWO:     rdata_q <= mask_two_q;
        OFS_ONCHIP_TRIM:  rdata_q <= onchip_trim_q;
        OFS_REMOTE_TRIM:  rdata_q <= remote_trim_q;
        OFS_REMOTE_UPPER: rdata_q <= remote_upper_q;
        OFS_REMOTE_LOWER: rdata_q <= remote_lower_q;
        default:          rdata_q <= RST_ZERO;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_unmapped_reads_zero: assert property (
    ce && reg_req.rd && reg_req.addr == OFS_RESERVED_A |=> reg_rdata == 8'h00)
    else $error("reserved address did not read zero");

  a_low_bits_stored: assert property (
    ce && conv.valid && conv.chan == CH_SUPPLY
    |=> low_q[0][LOW_POS_EVEN_CH +: 2] == $past(conv_value[1:0]))
    else $error("supply low bits not stored");

  a_low_read_locks: assert property (
    ce && reg_req.rd && reg_req.addr == OFS_LOW_GROUP1 |=> locked[1])
    else $error("low read did not freeze group");

  a_pair_held_frozen: assert property (
    ce && locked[0] |=> $stable(high_q[0]) && $stable(high_q[1]))
    else $error("frozen high register changed");

  a_high_read_unlocks: assert property (
    ce && locked[0] && reg_req.rd && reg_req.addr == OFS_HIGH_ONCHIP
    |=> !locked[0])
    else $error("high read did not release group");

  a_no_high_lock: assert property (
    ce && !locked[1] && reg_req.rd && is_high_addr(reg_req.addr)
    |=> !locked[1])
    else $error("high read froze a group");

  a_sibling_stays_free: assert property (
    ce && !locked[1] && reg_req.rd && reg_req.addr == OFS_LOW_GROUP0
    |=> !locked[1])
    else $error("low read froze another group");

  a_upper_flag_set: assert property (
    ce && conv.valid && conv.chan == CH_REMOTE
    && conv_value[9:2] > remote_upper_q && !mask_one_q[STAT1_REMOTE_HIGH]
    |=> status_one_q[STAT1_REMOTE_HIGH])
    else $error("upper violation flag not set");

  a_alert_follows_flags: assert property (
    ce |=> alert_out == (($past(|status_one_q) || $past(|status_two_q))
                         ? $past(setup_one_q[SETUP1_ALERT_POL])
                         : !$past(setup_one_q[SETUP1_ALERT_POL])))
    else $error("alert level wrong");

  a_release_applies_latest: assert property (
    ce && !locked[0] |=> high_q[1] == $past(live_q[1][9:2]))
    else $error("released register missed latest result");

  a_lower_flag_set: assert property (
    ce && conv.valid && conv.chan == CH_REMOTE
    && conv_value[9:2] <= remote_lower_q && !mask_one_q[STAT1_REMOTE_LOW]
    |=> status_one_q[STAT1_REMOTE_LOW])
    else $error("lower violation flag not set");

  a_masked_no_flag: assert property (
    ce && mask_one_q[STAT1_REMOTE_HIGH] && !status_one_q[STAT1_REMOTE_HIGH]
    |=> !status_one_q[STAT1_REMOTE_HIGH])
    else $error("masked violation set a flag");

  a_status_read_clears: assert property (
    ce && rd_status_one && !conv.valid |=> status_one_q == RST_ZERO)
    else $error("status flags not cleared by read");

  a_odd_low_stored: assert property (
    ce && conv.valid && conv.chan == CH_ONCHIP
    |=> low_q[0][LOW_POS_ODD_CH +: 2] == $past(conv_value[1:0]))
    else $error("on-chip low bits not stored");

  a_group_one_held: assert property (
    ce && locked[1] |=> $stable(high_q[2]) && $stable(high_q[3]))
    else $error("frozen high register changed");

endmodule // split_result_bank

// File: testbench/reg_host.sv
/*
  Host model that drives the register port of the split result bank.
  Assumes the bank takes one-cycle strobes on the rising core_clk edge
  and answers a read on that same edge.
*/
`timescale 1ns/1ps
module reg_host
  import split_result_pkg::*;
(
  input  wire logic       core_clk,
  output reg_req_s        reg_req,
  input  wire logic [7:0] reg_rdata
);
  // Extra idle cycles before each request, so the host can be slow.
  int idle_gap = 0;

  initial reg_req = '{rd: 1'h0, wr: 1'h0, addr: 8'h00, wdata: 8'h00};

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    repeat (idle_gap + 1) @(posedge core_clk);
    reg_req <= '{rd: 1'h0, wr: 1'h1, addr: a, wdata: d};
    @(posedge core_clk);
    // Released lines carry the inverse so a stale value is never reused.
    reg_req <= '{rd: 1'h0, wr: 1'h0, addr: ~a, wdata: ~d};
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    repeat (idle_gap + 1) @(posedge core_clk);
    reg_req <= '{rd: 1'h1, wr: 1'h0, addr: a,
                 wdata: ~reg_req.wdata};
    @(posedge core_clk);
    reg_req <= '{rd: 1'h0, wr: 1'h0, addr: ~a, wdata: reg_req.wdata};
    #1 d = reg_rdata;
  endtask
endmodule // reg_host

// File: testbench/split_result_bank_tb.sv
/*
  Self-checking testbench of the split result bank.
  Assumes the reg_host model on the register port; the bench itself
  offers conversion results.
*/
`timescale 1ns/1ps
module split_result_bank_tb
  import split_result_pkg::*;
;
  logic       core_clk = 1'h0;
  logic       srst     = 1'h1;
  logic       ce       = 1'h1;
  reg_req_s   reg_req;
  logic [7:0] reg_rdata;
  conv_s      conv     = '{valid: 1'h0, chan: 2'h0, value: 10'h000};
  logic       alert_out;
  int         fail_count  = 0;
  int         check_count = 0;
  int         cycles      = 0;
  logic [7:0] rd_v;
  logic [7:0] map_addr [20] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
    8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h18, 8'h19, 8'h1a, 8'h1d,
    8'h1e, 8'h1f, 8'h20, 8'h27, 8'h28, 8'h50};
  logic [9:0] lim_val [4] = '{10'h204, 10'h200, 10'h043, 10'h047};
  logic [7:0] lim_st  [4] = '{8'h04, 8'h00, 8'h08, 8'h00};

  always #12.5 core_clk = ~core_clk;

  split_result_bank u_dut (
    .core_clk  (core_clk),
    .srst      (srst),
    .ce        (ce),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata),
    .conv      (conv),
    .alert_out (alert_out)
  );

  reg_host u_host (
    .core_clk  (core_clk),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata)
  );

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_host.read_reg(a, rd_v);
    check(rd_v, exp);
  endtask

  task automatic send(input logic [1:0] ch, input logic [9:0] v);
    @(posedge core_clk);
    conv <= '{valid: 1'h1, chan: ch, value: v};
    @(posedge core_clk);
    conv <= '{valid: 1'h0, chan: ~ch, value: ~v};
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    srst <= 1'h1;
    repeat (16) @(posedge core_clk);
    srst <= 1'h0;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    do_reset();
    for (int i = 0; i < 20; i++) begin
      rd_chk(map_addr[i], {8{map_addr[i] == 8'h27}});
    end
    check({7'h00, alert_out}, 8'h01);
    $display("test reset_values done");

    for (int i = 10; i < 19; i++) begin
      u_host.write_reg(map_addr[i], 8'h5a ^ map_addr[i]);
      rd_chk(map_addr[i], 8'h5a ^ map_addr[i]);
    end
    u_host.write_reg(8'h07, 8'haa);
    u_host.write_reg(8'h50, 8'h3c);
    rd_chk(8'h07, 8'h00);
    rd_chk(8'h50, 8'h00);
    do_reset();
    rd_chk(8'h27, 8'hff);
    rd_chk(8'h18, 8'h00);
    @(posedge core_clk);
    ce <= 1'h0;
    u_host.write_reg(8'h19, 8'h33);
    @(posedge core_clk);
    ce <= 1'h1;
    rd_chk(8'h19, 8'h00);
    $display("test read_write done");

    send(CH_SUPPLY, 10'h2a5);
    send(CH_ONCHIP, 10'h13e);
    send(CH_REMOTE, 10'h1c7);
    send(CH_INPUT2, 10'h302);
    rd_chk(8'h06, 8'ha9);
    rd_chk(8'h09, 8'hc0);
    send(CH_ONCHIP, 10'h0a8);
    rd_chk(8'h07, 8'h2a);
    rd_chk(8'h03, 8'h04);
    rd_chk(8'h04, 8'h0e);
    $display("test split_result done");

    send(CH_SUPPLY, 10'h0ff);
    send(CH_SUPPLY, 10'h155);
    send(CH_ONCHIP, 10'h3fc);
    send(CH_REMOTE, 10'h011);
    rd_chk(8'h03, 8'h04);
    rd_chk(8'h07, 8'h2a);
    rd_chk(8'h06, 8'h55);
    rd_chk(8'h07, 8'hff);
    rd_chk(8'h08, 8'h71);
    rd_chk(8'h08, 8'h04);
    $display("test freeze done");

    u_host.idle_gap = 2;
    u_host.write_reg(8'h27, 8'h80);
    u_host.write_reg(8'h28, 8'h10);
    for (int i = 0; i < 4; i++) begin
      send(CH_REMOTE, lim_val[i]);
      check({7'h00, alert_out}, {7'h00, lim_st[i] == 8'h00});
      rd_chk(8'h00, lim_st[i]);
      rd_chk(8'h00, 8'h00);
      check({7'h00, alert_out}, 8'h01);
    end
    u_host.write_reg(8'h1d, 8'h04);
    send(CH_REMOTE, 10'h3ff);
    check({7'h00, alert_out}, 8'h01);
    rd_chk(8'h00, 8'h00);
    u_host.write_reg(8'h1d, 8'h00);
    u_host.write_reg(8'h18, 8'h08);
    repeat (2) @(posedge core_clk);
    #1;
    check({7'h00, alert_out}, 8'h00);
    send(CH_REMOTE, 10'h3ff);
    check({7'h00, alert_out}, 8'h01);
    rd_chk(8'h00, 8'h04);
    rd_chk(8'h01, 8'h00);
    check({7'h00, alert_out}, 8'h00);
    $display("test limits done");
    complete_run();
  end
endmodule // split_result_bank_tb
